// [shared/interrupt_control_pkg.sv]
package interrupt_control_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] ctrl_offset = 12'h000;
  localparam logic [11:0] src_offset = 12'h004;
  localparam logic [11:0] status_offset = 12'h008;

  // ****************************************
  // field positions
  // ****************************************
  localparam int global_irq_enable_bit = 7;
  localparam int peripheral_group_enable_bit = 6;
  localparam int timer_overflow_enable_bit = 5;
  localparam int edge_pin_irq_enable_bit = 4;
  localparam int port_change_enable_bit = 3;
  localparam int timer_overflow_flag_bit = 2;
  localparam int edge_pin_irq_flag_bit = 1;
  localparam int port_change_flag_bit = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] periph_reset = 8'h00;

  typedef struct packed {
    logic timer_overflow;
    logic edge_pin;
    logic port_change;
  } events_type;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
    logic access;
  } bus_req_type;

endpackage

// [src/interrupt_control_apb_slave.sv]
`timescale 1ns/1ps
module interrupt_control_apb_slave
  import interrupt_control_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  // decoded request
  output bus_req_type req
);

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    req.addr = paddr;
    req.write = pwrite;
    req.wdata = pwdata;
    req.access = psel & penable;
  end

endmodule

// [src/interrupt_control_irq_combine.sv]
`timescale 1ns/1ps
module interrupt_control_irq_combine
  import interrupt_control_pkg::*;
(
  // control state
  input wire logic [7:0] ctrl,
  input wire logic [7:0] periph_flags,
  input wire logic [7:0] periph_enables,
  // result
  output logic irq
);

  logic core_pending;
  logic periph_pending;

  always_comb begin
    core_pending = (ctrl[timer_overflow_enable_bit] & ctrl[timer_overflow_flag_bit])
      | (ctrl[edge_pin_irq_enable_bit] & ctrl[edge_pin_irq_flag_bit])
      | (ctrl[port_change_enable_bit] & ctrl[port_change_flag_bit]);
    // [R2] peripheral group gate
    periph_pending = ctrl[peripheral_group_enable_bit] & (|(periph_flags & periph_enables));
    // [R1] global gate
    irq = ctrl[global_irq_enable_bit] & (core_pending | periph_pending);
  end

endmodule

// [src/interrupt_control_ctrl.sv]
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
// What this block does
// [R1] bit 7 global enable; at 0 no interrupt reaches the core
// [R2] bit 6 peripheral group enable gates all peripheral sources
// [R3] bit 5 enables timer overflow interrupt
// [R4] bit 4 enables external edge pin interrupt
// [R5] bit 3 enables port pin change interrupt
// [R6] bit 2 timer overflow flag, set by hardware, cleared by software writing 0
// [R7] bit 1 edge pin flag, set by event, cleared by writing 0
// [R8] bit 0 port change flag, set on pin change, software clears it
// [R9] flags set regardless of enables; software clears before enabling
// [R10] request only when global enable and some enabled flag set
module interrupt_control_ctrl
  import interrupt_control_pkg::*;
#(
  parameter int periph_width = 8
)
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt sources: one-cycle event pulses and peripheral flag levels
  input wire events_type events,
  input wire logic [periph_width-1:0] periph_flags,
  // core side
  output logic irq_to_core,
  output logic [7:0] interrupt_control
);

  // ****************************************
  // bus decode
  // ****************************************
  bus_req_type req;
  logic [7:0] ctrl_reg;
  logic [7:0] periph_en_reg;
  logic [7:0] periph_flags_8;
  logic irq_next;
  logic wr_ctrl;
  logic wr_src;
  logic rd_hit;
  logic [31:0] rdata_next;

  interrupt_control_apb_slave u_slave (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .req(req)
  );

  always_comb begin
    periph_flags_8 = 8'h00;
    periph_flags_8[periph_width-1:0] = periph_flags;
  end

  assign wr_ctrl = req.access & req.write & (req.addr == ctrl_offset);
  assign wr_src = req.access & req.write & (req.addr == src_offset);

  // ****************************************
  // control register
  // ****************************************
  // enables are plain storage; flags are set-dominant
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= ctrl_reset;
    end else begin
      if (wr_ctrl) begin
        // [R1] global enable written
        ctrl_reg[global_irq_enable_bit] <= req.wdata[global_irq_enable_bit];
        // [R2] group enable written
        ctrl_reg[peripheral_group_enable_bit] <= req.wdata[peripheral_group_enable_bit];
        // [R3] timer enable written
        ctrl_reg[timer_overflow_enable_bit] <= req.wdata[timer_overflow_enable_bit];
        // [R4] edge enable written
        ctrl_reg[edge_pin_irq_enable_bit] <= req.wdata[edge_pin_irq_enable_bit];
        // [R5] change enable written
        ctrl_reg[port_change_enable_bit] <= req.wdata[port_change_enable_bit];
      end
      // [R6] timer flag set wins
      if (events.timer_overflow) begin
        ctrl_reg[timer_overflow_flag_bit] <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_reg[timer_overflow_flag_bit] <= req.wdata[timer_overflow_flag_bit];
      end
      // [R7] edge flag set wins
      if (events.edge_pin) begin
        ctrl_reg[edge_pin_irq_flag_bit] <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_reg[edge_pin_irq_flag_bit] <= req.wdata[edge_pin_irq_flag_bit];
      end
      // [R8] change flag set wins
      // [R9] no enable gates the set
      if (events.port_change) begin
        ctrl_reg[port_change_flag_bit] <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_reg[port_change_flag_bit] <= req.wdata[port_change_flag_bit];
      end
    end
  end

  // ****************************************
  // peripheral enable mask
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_en_reg <= periph_reset;
    end else if (wr_src) begin
      periph_en_reg <= req.wdata[7:0];
    end
  end

  // ****************************************
  // request to core
  // ****************************************
  interrupt_control_irq_combine u_combine (
    .ctrl(ctrl_reg),
    .periph_flags(periph_flags_8),
    .periph_enables(periph_en_reg),
    .irq(irq_next)
  );

  // [R10] registered request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_to_core <= 1'b0;
    end else begin
      irq_to_core <= irq_next;
    end
  end

  assign interrupt_control = ctrl_reg;

  // ****************************************
  // read data
  // ****************************************
  assign rd_hit = psel & ~penable & ~pwrite;

  always_comb begin
    case (paddr)
      ctrl_offset: rdata_next = {24'h000000, ctrl_reg};
      src_offset: rdata_next = {24'h000000, periph_en_reg};
      status_offset: rdata_next = {24'h000000, periph_flags_8};
      default: rdata_next = 32'h00000000;
    endcase
  end

  // captured in the setup cycle, so it stands through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_hit) begin
      prdata <= rdata_next;
    end
  end

endmodule

// [verification/interrupt_control_checker.sv]
`timescale 1ns/1ps
module interrupt_control_checker
  import interrupt_control_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  // sources and core
  input wire events_type events,
  input wire logic irq_to_core,
  input wire logic [7:0] interrupt_control
);
  // ****************************************
  // request and flag properties
  // ****************************************
  logic [7:0] ic;
  logic irq;
  assign ic = interrupt_control;
  assign irq = irq_to_core;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_global_gate: assert property (!ic[7] |=> !irq) else $error("irq with global off");
  a_tmr_irq: assert property (ic[7] && ic[5] && ic[2] |=> irq) else $error("tmr irq");
  a_pin_irq: assert property (ic[7] && ic[4] && ic[1] |=> irq) else $error("pin irq");
  a_port_irq: assert property (ic[7] && ic[3] && ic[0] |=> irq) else $error("port irq");
  a_tmr_flag: assert property (events.timer_overflow |=> ic[2]) else $error("tmr flag");
  a_pin_flag: assert property (events.edge_pin |=> ic[1]) else $error("pin flag");
  a_port_flag: assert property (events.port_change |=> ic[0]) else $error("port flag");
  a_flag_hold: assert property (!(psel && penable && pwrite) |=>
    (ic[2:0] & $past(ic[2:0])) == $past(ic[2:0])) else $error("flag lost");
endmodule

bind interrupt_control_ctrl interrupt_control_checker interrupt_control_checker_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .events, .irq_to_core, .interrupt_control);

// [verification/interrupt_control_src_model.sv]
`timescale 1ns/1ps
module interrupt_control_src_model
  import interrupt_control_pkg::*;
(
  // clock and requests
  input wire logic pclk,
  input wire logic [2:0] fire,
  // pulses to the block
  output events_type events
);
  // ****************************************
  // event pulses
  // ****************************************
  initial events = '0;
  always @(posedge pclk) begin
    events <= fire;
  end
endmodule

// [verification/core_interrupt_control_register_bench.sv]
`timescale 1ns/1ps
module core_interrupt_control_register_bench
  import interrupt_control_pkg::*;
;
  // ****************************************
  // harness
  // ****************************************
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, lf = 83990, q;
  logic pready, pslverr, irq_to_core;
  logic [7:0] interrupt_control, pflags = 0;
  logic [2:0] fire = 0;
  events_type events;
  int n_errors = 0, check_count = 0, cyc = 0, m = 0, pm = 0;
  initial forever #25 pclk = ~pclk;
  interrupt_control_src_model interrupt_control_src_model_inst (.pclk, .fire, .events);
  interrupt_control_ctrl interrupt_control_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .events, .periph_flags(pflags), .irq_to_core,
    .interrupt_control);
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task close_out;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
    if (w && a == ctrl_offset) m = d[7:0];
    if (w && a == src_offset) pm = d[7:0];
  endtask
  task ev(input logic [2:0] f);
    @(posedge pclk) fire <= f;
    @(posedge pclk) fire <= 0;
    m = m | f;
  endtask
  // model of the request, compared with ports and readback
  task chk_all;
    logic e;
    repeat (2) @(posedge pclk);
    #1;
    e = m[7] && ((m[5:3] & m[2:0]) != 0 || (m[6] && (pm & pflags) != 0));
    chk("irq", irq_to_core, e);
    chk("ctrl", interrupt_control, m);
    bus(0, ctrl_offset, 0);
    chk("ctrl read", q, m);
    chk("pslverr", pslverr, 0);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    chk_all;
    // flags rise with every enable off, then clear by zero
    for (int i = 0; i < 3; i++) begin
      ev(3'b001 << i);
      chk_all;
    end
    bus(1, ctrl_offset, 0);
    chk_all;
    repeat (24) begin
      lf = nxt(lf);
      @(posedge pclk) pflags <= lf[31:24];
      bus(1, src_offset, lf[23:16]);
      bus(1, ctrl_offset, lf[7:0]);
      chk_all;
      ev(lf[10:8]);
      chk_all;
      bus(1, status_offset, lf);
      bus(0, status_offset, 0);
      chk("status", q, pflags);
      bus(1, 12'h00c, lf);
      bus(0, 12'h00c, 0);
      chk("unmapped", q, 0);
      bus(0, src_offset, 0);
      chk("mask", q, pm);
    end
    // mid-run reset brings every register back to zero
    @(posedge pclk) presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    m = 0;
    pm = 0;
    chk_all;
    close_out;
  end
endmodule
